// ==== rtl/spi_port_pkg.sv ====
/*
 Constants for the serial port unit: select modes, reset values, timing.
 Assumes a 100 MHz core clock.
*/
package spi_port_pkg;
   localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
   localparam logic [1:0] SEL_FOUR_IN = 2'h1;
   localparam int SEL_HIGH_BIT = 1;
   localparam int SEL_LOW_BIT = 0;
   localparam logic [1:0] SEL_MODE_RESET = 2'h1;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [2:0] BITS_LAST = 3'h7;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SELECT_SETUP_NS = 20;
   localparam int SELECT_SETUP_CYC =
      (SELECT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== rtl/serial_port_unit.sv ====
/*
 Serial port unit: SPI master or slave, three- or four-wire, MSB first.
 Assumes the processor side clears flags by pulses and that pins outside
 resolve line levels from the output enables. Slave-side pins are async.
*/
// Summary of operation
// [R1] Bytes shift most-significant bit first; master drives data out from top bit.
// [R2] Slave-output line floats when disabled or as unselected four-wire slave.
// [R3] Three-wire slave drives slave-output continuously from shift register top bit.
// [R4] Unselected four-wire slave ignores incoming serial clock.
// [R5] Select mode 00: three-wire, select ignored, slave always selected.
// [R6] Select mode 01: select input selects slave; low select disables master.
// [R7] Select mode 1x: select is an output equal to mode low bit.
// [R8] Select line routed to a pin only in four-wire configurations.
// [R9] Master write goes to transmit buffer, loads empty shifter, starts clocking.
// [R10] Transfer-done flag set at end of every byte; raises interrupt request.
// [R11] Master shifts in slave bits while sending; full byte goes to receive buffer.
// [R12] Multi-master is default master mode: select mode 01, select an input.
// [R13] Low select in multi-master clears enables, sets mode fault until re-enabled.
// [R14] Enabled without master enable acts as slave following external clock.
// [R15] Slave counts clock edges; after eight, sets done flag, copies byte.
// [R16] Slave writes load empty shifter at once, else after last edge of transfer.
// [R17] Four-wire slave active only while select input low.
// [R18] Four-wire slave select falling edge clears bit counter.
// [R19] External master lowers select two system clocks before first clock edge.
// [R20] Three-wire slave bit counter cleared only by disabling and re-enabling.
// [R21] Three-wire slave must be the only slave on the bus.
// [R22] Clock polarity bit sets serial clock idle level.
// [R23] Clock phase bit picks first or second edge for data sampling.
// [R24] Write before transmit buffer empties is dropped and sets collision flag.
// [R25] Slave completion with unread receive byte sets overrun, keeps old byte.
// [R26] Slave synchronises clock, select and data, detecting edges before use.
// [R27] Master divides system clock by programmable divider, idles at polarity.
`timescale 1ns/1ps
module serial_port_unit (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   // Control
   input wire logic port_enable_set_in,
   input wire logic port_enable_clr_in,
   input wire logic master_enable_set_in,
   input wire logic master_enable_clr_in,
   input wire logic [1:0] select_mode_field_in,
   input wire logic clock_phase_bit_in,
   input wire logic clock_polarity_bit_in,
   input wire logic [7:0] clock_divider_in,
   input wire logic irq_enable_in,
   // Data window
   input wire logic data_wr_in,
   input wire logic [7:0] data_wdata_in,
   input wire logic data_rd_in,
   output logic [7:0] data_rdata_out,
   // Flags and status, cleared by pulses
   input wire logic flag_clr_done_in,
   input wire logic flag_clr_write_collision_flag_in,
   input wire logic flag_clr_mode_fault_flag_in,
   input wire logic flag_clr_ovr_in,
   output logic port_enable_bit_out,
   output logic master_enable_bit_out,
   output logic transfer_done_flag_out,
   output logic write_collision_flag_out,
   output logic mode_fault_flag_out,
   output logic receive_overrun_flag_out,
   output logic busy_out,
   output logic slave_selected_out,
   output logic irq_out,
   // Serial pins
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_out,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe_out,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire logic slave_select_line_in,
   output logic slave_select_line_out,
   output logic slave_select_line_oe_out,
   output logic slave_select_pin_mapped_out
);

   typedef enum logic [2:0] {
      M_IDLE = 3'h1,
      M_LEAD = 3'h2,
      M_TRAIL = 3'h4
   } mstate_e;

   logic [2:0] sclk_sync_reg, ss_sync_reg;
   logic [1:0] mosi_sync_reg, miso_sync_reg;
   logic en_reg, master_enable_bit_reg;
   logic [7:0] shift_reg, txbuf_reg, rxbuf_reg;
   logic shift_full_reg, txbuf_full_reg, rx_full_reg;
   logic [2:0] bitcnt_reg;
   logic done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovr_reg;
   logic sample_reg;
   mstate_e mstate_reg;
   logic [7:0] div_cnt_reg;
   logic sclk_drv_reg;
   logic mode_three, mode_four_in, slave_act, sclk_rise, sclk_fall, ss_fall;
   logic lead_edge, trail_edge, byte_end, slave_end, master_end, div_tick;
   logic load_shift, rx_take, rx_bit;

   // Synchronisers; stage 0 read only by stage 1
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sclk_sync_reg <= 3'h0;
         ss_sync_reg <= 3'h7;
         mosi_sync_reg <= 2'h0;
         miso_sync_reg <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in}; // R26
         ss_sync_reg <= {ss_sync_reg[1:0], slave_select_line_in};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
         miso_sync_reg <= {miso_sync_reg[0], miso_in};
      end
   end

   // Mode decode
   assign mode_three = (select_mode_field_in == spi_port_pkg::SEL_THREE_WIRE); // R5
   assign mode_four_in = (select_mode_field_in == spi_port_pkg::SEL_FOUR_IN); // R12
   assign ss_fall = ss_sync_reg[2] & ~ss_sync_reg[1];
   // Three-wire slave is always selected; four-wire needs select low
   assign slave_act = en_reg & ~master_enable_bit_reg & (mode_three | ~ss_sync_reg[1]); // R4 R17
   assign sclk_rise = ~sclk_sync_reg[2] & sclk_sync_reg[1];
   assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
   // Leading edge leaves idle level; phase picks which edge samples
   assign lead_edge = clock_polarity_bit_in ? sclk_fall : sclk_rise; // R22
   assign trail_edge = clock_polarity_bit_in ? sclk_rise : sclk_fall;

   // Master clock divider: half period is divider+1 core clocks
   assign div_tick = (div_cnt_reg == clock_divider_in); // R27
   assign master_end = (mstate_reg == M_TRAIL) & div_tick & (bitcnt_reg == spi_port_pkg::BITS_LAST);
   assign slave_end = slave_act & trail_edge & (bitcnt_reg == spi_port_pkg::BITS_LAST); // R15
   assign byte_end = master_end | slave_end;
   assign load_shift = txbuf_full_reg & (~shift_full_reg | byte_end); // R9 R16
   assign rx_take = byte_end & ~(slave_end & rx_full_reg); // R25
   // Incoming line bit of the active role, already synchronised
   assign rx_bit = master_enable_bit_reg ? miso_sync_reg[1] : mosi_sync_reg[1];

   // Enables; mode fault clears both, software sets again
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         en_reg <= 1'b0;
         master_enable_bit_reg <= 1'b0;
      end else if (en_reg & master_enable_bit_reg & mode_four_in & ~ss_sync_reg[1]) begin
         en_reg <= 1'b0; // R13 R6
         master_enable_bit_reg <= 1'b0;
      end else begin
         if (port_enable_set_in) en_reg <= 1'b1;
         else if (port_enable_clr_in) en_reg <= 1'b0;
         if (master_enable_set_in) master_enable_bit_reg <= 1'b1;
         else if (master_enable_clr_in) master_enable_bit_reg <= 1'b0;
      end
   end

   // Transmit buffer; collision drops the write
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         txbuf_reg <= 8'h00;
         txbuf_full_reg <= 1'b0;
      end else if (data_wr_in & ~txbuf_full_reg) begin
         txbuf_reg <= data_wdata_in;
         txbuf_full_reg <= 1'b1;
      end else if (load_shift) begin
         txbuf_full_reg <= 1'b0;
      end
   end

   // Master sequencer
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mstate_reg <= M_IDLE;
         div_cnt_reg <= spi_port_pkg::DIV_RESET;
         sclk_drv_reg <= 1'b0;
      end else if (!(en_reg & master_enable_bit_reg)) begin
         mstate_reg <= M_IDLE;
         div_cnt_reg <= spi_port_pkg::DIV_RESET;
         sclk_drv_reg <= clock_polarity_bit_in;
      end else begin
         div_cnt_reg <= (div_tick | mstate_reg == M_IDLE) ? 8'h00 : div_cnt_reg + 8'h01;
         unique case (mstate_reg)
            M_IDLE: begin
               sclk_drv_reg <= clock_polarity_bit_in; // R27
               if (shift_full_reg) mstate_reg <= M_LEAD; // R9
            end
            M_LEAD: if (div_tick) begin
               sclk_drv_reg <= ~clock_polarity_bit_in;
               mstate_reg <= M_TRAIL;
            end
            M_TRAIL: if (div_tick) begin
               sclk_drv_reg <= clock_polarity_bit_in;
               mstate_reg <= (bitcnt_reg == spi_port_pkg::BITS_LAST) ?
                             (load_shift ? M_LEAD : M_IDLE) : M_LEAD;
            end
         endcase
      end
   end

   // Shift register, sample latch and bit counter
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_reg <= 8'h00;
         shift_full_reg <= 1'b0;
         bitcnt_reg <= 3'h0;
         sample_reg <= 1'b0;
      end else if (!en_reg) begin
         shift_full_reg <= 1'b0;
         bitcnt_reg <= 3'h0; // R20
      end else begin
         if (~master_enable_bit_reg & ~mode_three & ss_fall)
            bitcnt_reg <= 3'h0; // R18
         // Phase 1 latches the outgoing top bit on the lead edge, so the
         // bit is not shifted away before the far side has sampled it
         if (master_enable_bit_reg) begin
            if (mstate_reg == M_LEAD & div_tick) begin
               if (clock_phase_bit_in) sample_reg <= shift_reg[7];
               else sample_reg <= miso_sync_reg[1]; // R11 R23
            end
            if (mstate_reg == M_TRAIL & div_tick) begin
               bitcnt_reg <= bitcnt_reg + 3'h1;
               if (clock_phase_bit_in) shift_reg <= {shift_reg[6:0], miso_sync_reg[1]};
               else shift_reg <= {shift_reg[6:0], sample_reg}; // R1
            end
         end else if (slave_act) begin // R14
            if (lead_edge) begin
               if (clock_phase_bit_in) sample_reg <= shift_reg[7];
               else sample_reg <= mosi_sync_reg[1]; // R23
            end
            if (trail_edge) begin
               bitcnt_reg <= bitcnt_reg + 3'h1; // R15
               if (clock_phase_bit_in) shift_reg <= {shift_reg[6:0], mosi_sync_reg[1]};
               else shift_reg <= {shift_reg[6:0], sample_reg};
            end
         end
         if (load_shift) begin
            shift_reg <= txbuf_reg; // R16
            shift_full_reg <= 1'b1;
         end else if (byte_end) begin
            shift_full_reg <= 1'b0;
         end
      end
   end

   // Receive buffer; phase 1 takes the last bit straight from the line
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rxbuf_reg <= 8'h00;
         rx_full_reg <= 1'b0;
      end else if (rx_take) begin
         rxbuf_reg <= clock_phase_bit_in ? {shift_reg[6:0], rx_bit}
                                         : {shift_reg[6:0], sample_reg}; // R11 R15
         rx_full_reg <= 1'b1;
      end else if (data_rd_in) begin
         rx_full_reg <= 1'b0;
      end
   end

   // Sticky flags; a set beats a clear in the same cycle
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_reg <= 1'b0;
         write_collision_flag_reg <= 1'b0;
         mode_fault_flag_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end else begin
         done_reg <= byte_end | (done_reg & ~flag_clr_done_in); // R10
         write_collision_flag_reg <= (data_wr_in & txbuf_full_reg) | (write_collision_flag_reg & ~flag_clr_write_collision_flag_in); // R24
         mode_fault_flag_reg <= (en_reg & master_enable_bit_reg & mode_four_in & ~ss_sync_reg[1])
                     | (mode_fault_flag_reg & ~flag_clr_mode_fault_flag_in); // R13
         ovr_reg <= (slave_end & rx_full_reg) | (ovr_reg & ~flag_clr_ovr_in); // R25
      end
   end

   // Pin drive
   assign sclk_out = sclk_drv_reg;
   assign sclk_oe_out = en_reg & master_enable_bit_reg;
   assign mosi_out = clock_phase_bit_in ? sample_reg : shift_reg[7]; // R1
   assign mosi_oe_out = en_reg & master_enable_bit_reg;
   assign miso_out = clock_phase_bit_in ? sample_reg : shift_reg[7]; // R3
   assign miso_oe_out = en_reg & ~master_enable_bit_reg & (mode_three | ~ss_sync_reg[1]); // R2
   assign slave_select_line_out = select_mode_field_in[spi_port_pkg::SEL_LOW_BIT]; // R7
   assign slave_select_line_oe_out = en_reg & select_mode_field_in[spi_port_pkg::SEL_HIGH_BIT];
   assign slave_select_pin_mapped_out = ~mode_three; // R8

   // Status outputs
   assign data_rdata_out = rxbuf_reg;
   assign port_enable_bit_out = en_reg;
   assign master_enable_bit_out = master_enable_bit_reg;
   assign transfer_done_flag_out = done_reg;
   assign write_collision_flag_out = write_collision_flag_reg;
   assign mode_fault_flag_out = mode_fault_flag_reg;
   assign receive_overrun_flag_out = ovr_reg;
   assign busy_out = shift_full_reg;
   assign slave_selected_out = ~ss_sync_reg[1];
   assign irq_out = irq_enable_in & (done_reg | write_collision_flag_reg | mode_fault_flag_reg | ovr_reg); // R10

   // Assertions
   property p_float;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (!en_reg) |-> !miso_oe_out;
   endproperty
   a_float: assert property (p_float) else $error("miso driven while disabled"); // R2

   property p_fault;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (en_reg & master_enable_bit_reg & mode_four_in & ~ss_sync_reg[1]) |=> (!en_reg && !master_enable_bit_reg && mode_fault_flag_reg);
   endproperty
   a_fault: assert property (p_fault) else $error("mode fault not taken"); // R13

   property p_done;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      byte_end |=> done_reg;
   endproperty
   a_done: assert property (p_done) else $error("done flag missing"); // R10

   property p_write_collision_flag;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (data_wr_in & txbuf_full_reg) |=> (write_collision_flag_reg && $stable(txbuf_reg));
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision write not dropped"); // R24

   property p_ovr;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (slave_end & rx_full_reg) |=> (ovr_reg && $stable(rxbuf_reg));
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun handling wrong"); // R25

   property p_ss_out;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      select_mode_field_in[1] |-> (slave_select_line_out == select_mode_field_in[0]);
   endproperty
   a_ss_out: assert property (p_ss_out) else $error("select output level wrong"); // R7

   property p_idle;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mstate_reg == M_IDLE && en_reg && master_enable_bit_reg) ##1 (mstate_reg == M_IDLE)
      |-> sclk_drv_reg == $past(clock_polarity_bit_in);
   endproperty
   a_idle: assert property (p_idle) else $error("clock idle level wrong"); // R22

   property p_start;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (en_reg && master_enable_bit_reg && mstate_reg == M_IDLE && shift_full_reg) |=> mstate_reg == M_LEAD;
   endproperty
   a_start: assert property (p_start) else $error("master did not start"); // R9

   property p_cnt;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (en_reg && ~master_enable_bit_reg && ~mode_three && ss_fall) |=> (bitcnt_reg == 3'h0);
   endproperty
   a_cnt: assert property (p_cnt) else $error("counter not cleared"); // R18

   c_master: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) master_end);
   c_slave: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) slave_end);
   c_fault: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $rose(mode_fault_flag_reg));
   c_ovr: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $rose(ovr_reg));

endmodule // serial_port_unit

// ==== test/spi_far_slave_model.sv ====
/*
 Behavioural far-side slave for master-mode runs: clock idle low, first edge samples.
 Assumes the bench resolves the shared lines and enables it only while the unit masters.
*/
`timescale 1ns/1ps
module spi_far_slave_model (
   // Serial lines
   input wire logic sclk_in,
   input wire logic mosi_in,
   output logic miso_out,
   // Control from the bench
   input wire logic drive_in,
   input wire logic load_in,
   input wire logic [7:0] tx_byte_in,
   output logic [7:0] rx_byte_out
);
   logic [7:0] tx_reg = 8'h00;
   logic last_reg = 1'b0;
   initial rx_byte_out = 8'h00;
   // Capture on the leading edge, top bit first
   always @(posedge sclk_in) rx_byte_out <= {rx_byte_out[6:0], mosi_in};
   // Rotate so the same byte repeats on every transfer
   always @(negedge sclk_in or posedge load_in) begin
      if (load_in) tx_reg <= tx_byte_in;
      else tx_reg <= {tx_reg[6:0], tx_reg[7]};
   end
   // Released line shows the inverse of the last bit, never a stale level
   always @(tx_reg or drive_in) begin
      if (drive_in) last_reg = tx_reg[7];
   end
   assign miso_out = drive_in ? tx_reg[7] : ~last_reg;
endmodule // spi_far_slave_model

// ==== test/serial_port_unit_tb.sv ====
/*
 Self-checking bench for the serial port unit, master and slave roles.
 Assumes the far slave model beside it; bench acts as the external master.
*/
`timescale 1ns/1ps
module serial_port_unit_tb;
   logic core_clk = 1'b0, rst_b = 1'b0, pe_set = 1'b0, pe_clr = 1'b0, ms_set = 1'b0;
   logic ms_clr = 1'b0, pol = 1'b0, irq_en = 1'b1, wr = 1'b0, rd = 1'b0, pl_load = 1'b0;
   logic tb_sclk = 1'b0, tb_mosi = 1'b0, tb_sel = 1'b1, pha = 1'b0;
   logic [1:0] sel_mode = 2'h1;
   logic [3:0] clr = 4'h0;
   logic [7:0] div = 8'h03, wdata = 8'h00, got, rdata, pl_rx;
   logic pe_b, ms_b, done, write_collision_flag, mode_fault_flag, ovr, busy, slv, irq, mapped, pl_miso;
   logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe;
   wire logic sclk_w = sclk_oe ? sclk_o : tb_sclk;
   wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
   wire logic miso_w = miso_oe ? miso_o : pl_miso;
   wire logic sel_w = sel_oe ? sel_o : tb_sel;
   int err_count = 0, total_checks = 0;

   serial_port_unit u_dut (.core_clk_in(core_clk), .rst_b_in(rst_b),
      .port_enable_set_in(pe_set), .port_enable_clr_in(pe_clr),
      .master_enable_set_in(ms_set), .master_enable_clr_in(ms_clr),
      .select_mode_field_in(sel_mode), .clock_phase_bit_in(pha),
      .clock_polarity_bit_in(pol), .clock_divider_in(div), .irq_enable_in(irq_en),
      .data_wr_in(wr), .data_wdata_in(wdata), .data_rd_in(rd), .data_rdata_out(rdata),
      .flag_clr_done_in(clr[0]), .flag_clr_write_collision_flag_in(clr[1]), .flag_clr_mode_fault_flag_in(clr[2]),
      .flag_clr_ovr_in(clr[3]), .port_enable_bit_out(pe_b), .master_enable_bit_out(ms_b),
      .transfer_done_flag_out(done), .write_collision_flag_out(write_collision_flag),
      .mode_fault_flag_out(mode_fault_flag), .receive_overrun_flag_out(ovr), .busy_out(busy),
      .slave_selected_out(slv), .irq_out(irq), .sclk_in(sclk_w), .sclk_out(sclk_o),
      .sclk_oe_out(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
      .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe),
      .slave_select_line_in(sel_w), .slave_select_line_out(sel_o),
      .slave_select_line_oe_out(sel_oe), .slave_select_pin_mapped_out(mapped));

   spi_far_slave_model u_far (.sclk_in(sclk_w), .mosi_in(mosi_w), .miso_out(pl_miso),
      .drive_in(ms_b), .load_in(pl_load), .tx_byte_in(8'h3c), .rx_byte_out(pl_rx));

   // Free-running core clock
   initial forever #5 core_clk = ~core_clk;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Disable, then re-enable in the given mode; also restarts the bit counter
   task automatic cfg(input logic [1:0] mode, input logic mst);
      @(negedge core_clk) {pe_clr, ms_clr, sel_mode, clr, rd} = {2'b11, mode, 5'h1f};
      @(negedge core_clk) {pe_clr, ms_clr, pe_set, ms_set, clr, rd} = {3'b001, mst, 5'h0};
      @(negedge core_clk) {pe_set, ms_set} = 2'b00;
   endtask

   task automatic wr_byte(input logic [7:0] v);
      @(negedge core_clk) {wr, wdata} = {1'b1, v};
      @(negedge core_clk) wr = 1'b0;
   endtask

   task automatic wait_done;
      int n;
      for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge core_clk);
      chk("done wait", 8'h1, {7'h0, done});
   endtask

   // Bench as external master, idle-low clock, 125 ns period
   task automatic xfer(input logic [7:0] tx, input logic lvl, output logic [7:0] rx);
      int i;
      @(negedge core_clk) tb_sel = lvl;
      repeat (3) @(negedge core_clk);
      for (i = 7; i >= 0; i--) begin
         if (!pha) tb_mosi = tx[i];
         #62.5 tb_sclk = 1'b1;
         if (pha) tb_mosi = tx[i];
         else rx[i] = miso_w;
         #62.5 tb_sclk = 1'b0;
         if (pha) rx[i] = miso_w;
      end
      repeat (4) @(negedge core_clk);
      tb_sel = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask

   task automatic test_master;
      @(negedge core_clk) pl_load = 1'b1;
      @(negedge core_clk) pl_load = 1'b0;
      cfg(2'h0, 1'b1);
      wr_byte(8'ha5);
      repeat (2) @(negedge core_clk);
      wr_byte(8'h5a);
      wr_byte(8'h77);
      chk("write_collision_flag", 8'h1, {7'h0, write_collision_flag});
      chk("irq", 8'h1, {7'h0, irq});
      wait_done;
      @(negedge core_clk) clr[0] = 1'b1;
      @(negedge core_clk) clr[0] = 1'b0;
      wait_done;
      chk("far rx", 8'h5a, pl_rx);
      chk("rx buffer", 8'h3c, rdata);
      repeat (60) @(negedge core_clk);
      chk("busy", 8'h0, {7'h0, busy});
      chk("sclk idle", 8'h0, {7'h0, sclk_w});
      pol = 1'b1;
      cfg(2'h0, 1'b1);
      chk("sclk idle hi", 8'h1, {7'h0, sclk_w});
      pol = 1'b0;
   endtask

   task automatic test_slave4;
      cfg(2'h1, 1'b0);
      wr_byte(8'hc3);
      xfer(8'h96, 1'b0, got);
      chk("miso bits", 8'hc3, got);
      chk("slave rx", 8'h96, rdata);
      chk("done", 8'h1, {7'h0, done});
      chk("miso oe", 8'h0, {7'h0, miso_oe});
      xfer(8'h69, 1'b0, got);
      chk("overrun", 8'h1, {7'h0, ovr});
      chk("kept rx", 8'h96, rdata);
      cfg(2'h1, 1'b0);
      xfer(8'h55, 1'b1, got);
      chk("unselected", 8'h0, {7'h0, done});
   endtask

   task automatic test_slave3;
      cfg(2'h0, 1'b0);
      chk("3w oe", 8'h1, {7'h0, miso_oe});
      chk("3w map", 8'h0, {7'h0, mapped});
      wr_byte(8'ha1);
      xfer(8'h1e, 1'b1, got);
      chk("3w rx", 8'h1e, rdata);
      chk("3w miso", 8'ha1, got);
      // Second-edge phase, set while the slave is still enabled, then reconfigured
      pha = 1'b1;
      cfg(2'h0, 1'b0);
      wr_byte(8'h4b);
      xfer(8'hd2, 1'b1, got);
      chk("pha1 rx", 8'hd2, rdata);
      chk("pha1 miso", 8'h4b, got);
      pha = 1'b0;
      cfg(2'h0, 1'b0);
   endtask

   task automatic test_select;
      tb_sel = 1'b1;
      cfg(2'h1, 1'b1);
      @(negedge core_clk) tb_sel = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("mode_fault_flag", 8'h1, {7'h0, mode_fault_flag});
      chk("selected", 8'h1, {7'h0, slv});
      chk("enables", 8'h0, {6'h0, pe_b, ms_b});
      tb_sel = 1'b1;
      cfg(2'h2, 1'b1);
      chk("sel out", 8'h2, {6'h0, sel_oe, sel_w});
      chk("sel map", 8'h1, {7'h0, mapped});
      cfg(2'h3, 1'b1);
      chk("sel high", 8'h1, {7'h0, sel_w});
   endtask

   // Main sequence
   initial begin
      repeat (12) @(negedge core_clk);
      rst_b = 1'b1;
      @(negedge core_clk);
      chk("reset oe", 8'h0, {4'h0, sclk_oe, mosi_oe, miso_oe, sel_oe});
      test_master;
      test_slave4;
      test_slave3;
      test_select;
      tally_and_finish;
   end

   // Watchdog well beyond the expected run of some 8 us
   initial begin
      #200000;
      err_count++;
      tally_and_finish;
   end
endmodule // serial_port_unit_tb
